// >>> pbt_timers.sv
// four paired 16/32-bit timers behind an ahb-lite slave
`timescale 1ns/1ns
// Function
// R1 - four independent 16-bit timers, interval or event counting, 16-bit by default
// R2 - modes: internal clock, gated internal clock, external clock counting
// R3 - timers two/three and four/five can join into 32-bit timers
// R4 - joined timers offer the same three modes
// R5 - control bit 3 set joins the pair, clear keeps two 16-bit timers
// R6 - pairing bit exists only on even timers
// R7 - control bit 1 picks external pin clock or internal clock
// R8 - in 32-bit mode the even control register governs the pair
// R9 - software clears the odd idle-stop bit to keep a pair running in idle
// R10 - each timer has a selectable prescaler before its counter
// R11 - timers keep counting in idle unless told to stop
// R12 - only timers two and three serve as capture/compare time base
// R13 - only timer three triggers the converter
// R14 - clear, set and invert aliases change bits in one write
// R15 - software avoids register access right after disabling at 1:1 divisor
// R16 - count steps per prescaled tick, wraps to zero at period, raises flag
// R17 - paired: even holds low half, odd high half, flag on odd
module pbt_timers #(
  parameter int NTMR = pbt_pkg::NTMR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NTMR-1:0] timer_ext_clock_pin,
  input wire logic cpu_idle,
  output logic irq,
  output logic adc_trigger,
  output logic [15:0] timebase_a,
  output logic [15:0] timebase_b
);

  localparam int CW = pbt_pkg::CNT_W;
  localparam int AW = pbt_pkg::ADDR_W;

  // ===========================================
  // bus slave
  pbt_pkg::pbt_bus_e bus_q;
  logic [AW-1:0] addr_q;
  logic wr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic accept;
  logic glob;
  logic [1:0] tsel;
  logic [1:0] rsel;
  logic [1:0] aop;
  logic map_ok;
  logic [CW-1:0] wd;
  logic [31:0] rdata;

  wire [CW-1:0] ctl_v [NTMR];
  wire [CW-1:0] cnt_v [NTMR];
  wire [CW-1:0] per_v [NTMR];
  wire [NTMR-1:0] tick_v;
  wire [NTMR-1:0] fset;
  wire [NTMR-1:0] cwr_v;
  logic [NTMR-1:0] sts_q;
  logic [NTMR-1:0] msk_q;
  logic [NTMR-1:0] sts_d;
  logic sts_wr;
  logic msk_wr;
  logic irq_q;
  logic adc_q;

  assign accept = hsel & hready & (htrans == pbt_pkg::HTRANS_NONSEQ);
  assign glob = addr_q[pbt_pkg::GLOB_BIT];
  assign tsel = addr_q[pbt_pkg::TSEL_LSB +: 2];
  assign rsel = addr_q[pbt_pkg::RSEL_LSB +: 2];
  assign aop = addr_q[pbt_pkg::OP_LSB +: 2];
  assign wd = hwdata[CW-1:0];

  always_comb begin
    map_ok = (addr_q[AW-1:pbt_pkg::GLOB_BIT+1] == pbt_pkg::HI_ZERO);
    if (glob) begin
      map_ok = map_ok && (rsel <= pbt_pkg::GREG_MSK);
    end else begin
      map_ok = map_ok && (rsel <= pbt_pkg::REG_PER);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= accept & hwrite;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= '0;
    end else if (accept) begin
      addr_q <= haddr[AW-1:0];
    end
  end

  // one wait cycle per read so the data leaves from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= pbt_pkg::BUS_IDLE;
    end else begin
      case (bus_q)
        pbt_pkg::BUS_IDLE: begin
          if (accept && !hwrite) begin
            bus_q <= pbt_pkg::BUS_READ;
          end
        end
        pbt_pkg::BUS_READ: begin
          bus_q <= pbt_pkg::BUS_IDLE;
        end
        default: begin
          bus_q <= pbt_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= !(bus_q == pbt_pkg::BUS_IDLE && accept && !hwrite);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= '0;
    end else if (bus_q == pbt_pkg::BUS_READ) begin
      hrdata_q <= rdata;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;

  // ===========================================
  // read mux
  always_comb begin
    rdata = '0;
    if (map_ok) begin
      if (glob) begin
        if (rsel == pbt_pkg::GREG_STS) begin
          rdata[NTMR-1:0] = sts_q;
        end else begin
          rdata[NTMR-1:0] = msk_q;
        end
      end else begin
        case (rsel)
          pbt_pkg::REG_CTL: rdata[CW-1:0] = ctl_v[tsel];
          pbt_pkg::REG_CNT: rdata[CW-1:0] = cnt_v[tsel];
          default: rdata[CW-1:0] = per_v[tsel];
        endcase
      end
    end
  end

  // ===========================================
  // timers
  for (genvar gi = 0; gi < NTMR; gi++) begin : g_tmr
    localparam int E = gi - (gi % 2);
    localparam int O = E + 1;
    localparam logic [CW-1:0] WMASK =
        (gi % 2 == 0) ? pbt_pkg::CTL_MASK_EVEN : pbt_pkg::CTL_MASK_ODD;
    logic [CW-1:0] ctl_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] per_q;
    logic [pbt_pkg::PRE_W-1:0] pre_q;
    logic pin_prev_q;
    logic hit;
    logic pair;
    logic stop;
    logic en_in;
    logic step;
    logic wrap;
    logic inc;
    logic flag;
    logic pin_rise;
    logic cwr;

    assign hit = wr_q & map_ok & ~glob & (tsel == 2'(gi));
    assign pair = ctl_v[E][pbt_pkg::CTL_PAIR]; // see R5
    assign cwr = hit && (rsel == pbt_pkg::REG_CNT);
    assign pin_rise = timer_ext_clock_pin[gi] & ~pin_prev_q;
    assign ctl_v[gi] = ctl_q;
    assign cnt_v[gi] = cnt_q;
    assign per_v[gi] = per_q;
    assign cwr_v[gi] = cwr;

    // ===========================================
    // clock select and gate
    always_comb begin
      // idle stop: a pair also halts if the odd idle-stop bit is left set
      stop = cpu_idle & (ctl_q[pbt_pkg::CTL_SIDL]
          | (pair & ctl_v[O][pbt_pkg::CTL_SIDL])); // see R11 see R9
      en_in = ctl_q[pbt_pkg::CTL_ON] & ~stop;
      if (ctl_q[pbt_pkg::CTL_CS]) begin
        en_in = en_in & pin_rise; // see R7 see R2
      end else if (ctl_q[pbt_pkg::CTL_GATE]) begin
        en_in = en_in & timer_ext_clock_pin[gi]; // see R2
      end
    end

    // ===========================================
    // prescaler, >= so a smaller prescale chosen mid-count still ticks
    assign tick_v[gi] = en_in & (pre_q >= pbt_pkg::pbt_pre_lim(
        ctl_q[pbt_pkg::CTL_PS_LSB +: 3])); // see R10

    // ===========================================
    // step and wrap
    always_comb begin
      if (pair) begin
        // joined: even control drives both halves
        step = tick_v[E]; // see R8 see R4 see R3
        wrap = ({cnt_v[O], cnt_v[E]} == {per_v[O], per_v[E]}); // see R17
        inc = (gi == E) ? 1'b1 : (cnt_v[E] == pbt_pkg::CNT_MAX);
        flag = (gi == O) & step & wrap & ~(cwr_v[E] | cwr_v[O]); // see R17
      end else begin
        step = tick_v[gi]; // see R1
        wrap = (cnt_q == per_q);
        inc = 1'b1;
        flag = step & wrap & ~cwr; // see R16
      end
    end
    assign fset[gi] = flag;

    // ===========================================
    // registers
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pin_prev_q <= 1'b0;
      end else begin
        pin_prev_q <= timer_ext_clock_pin[gi];
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pre_q <= '0;
      end else if (!ctl_q[pbt_pkg::CTL_ON]) begin
        pre_q <= '0;
      end else if (en_in) begin
        pre_q <= tick_v[gi] ? '0 : pre_q + 1'b1;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ctl_q <= pbt_pkg::CTL_RST;
      end else if (hit && rsel == pbt_pkg::REG_CTL) begin
        ctl_q <= pbt_pkg::pbt_apply(ctl_q, wd, aop) & WMASK; // see R14 see R6
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        per_q <= pbt_pkg::PER_RST;
      end else if (hit && rsel == pbt_pkg::REG_PER) begin
        per_q <= pbt_pkg::pbt_apply(per_q, wd, aop); // see R14
      end
    end

    // a count write beats a tick, so no wrap and no flag then
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q <= pbt_pkg::CNT_RST;
      end else if (cwr) begin
        cnt_q <= pbt_pkg::pbt_apply(cnt_q, wd, aop); // see R14
      end else if (step) begin
        if (wrap) begin
          cnt_q <= pbt_pkg::CNT_RST; // see R16
        end else if (inc) begin
          cnt_q <= cnt_q + 1'b1; // see R16
        end
      end
    end
  end

  // ===========================================
  // interrupt status and mask
  assign sts_wr = wr_q && map_ok && glob && (rsel == pbt_pkg::GREG_STS);
  assign msk_wr = wr_q && map_ok && glob && (rsel == pbt_pkg::GREG_MSK);

  always_comb begin
    sts_d = sts_q;
    if (sts_wr) begin
      sts_d = sts_q & ~wd[NTMR-1:0];
    end
    sts_d = sts_d | fset;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msk_q <= '0;
    end else if (msk_wr) begin
      msk_q <= NTMR'(pbt_pkg::pbt_apply(CW'(msk_q), wd, aop));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sts_q & msk_q);
    end
  end

  // one-cycle pulse, one clock after timer three's flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adc_q <= 1'b0;
    end else begin
      adc_q <= fset[1]; // see R13
    end
  end

  assign irq = irq_q;
  assign adc_trigger = adc_q;
  assign timebase_a = cnt_v[0]; // see R12
  assign timebase_b = cnt_v[1]; // see R12

endmodule : pbt_timers

// >>> pbt_pkg.sv
// constants and types for the paired timer block
package pbt_pkg;

  // ===========================================
  // sizes
  localparam int NTMR = 4;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam int ADDR_W = 12;

  // ===========================================
  // address fields
  localparam int GLOB_BIT = 8;
  localparam int TSEL_LSB = 6;
  localparam int RSEL_LSB = 4;
  localparam int OP_LSB = 2;
  localparam logic [2:0] HI_ZERO = 3'h0;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_CNT = 2'h1;
  localparam logic [1:0] REG_PER = 2'h2;
  localparam logic [1:0] GREG_STS = 2'h0;
  localparam logic [1:0] GREG_MSK = 2'h1;
  localparam logic [1:0] OP_WR = 2'h0;
  localparam logic [1:0] OP_CLR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;

  // ===========================================
  // control fields
  localparam int CTL_ON = 15;
  localparam int CTL_SIDL = 13;
  localparam int CTL_GATE = 7;
  localparam int CTL_PS_LSB = 4;
  localparam int CTL_PAIR = 3;
  localparam int CTL_CS = 1;
  localparam logic [CNT_W-1:0] CTL_MASK_EVEN = 16'hA0FA;
  localparam logic [CNT_W-1:0] CTL_MASK_ODD = 16'hA0F2;
  localparam logic [CNT_W-1:0] CTL_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] PER_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ===========================================
  // types and helpers
  typedef enum logic {BUS_IDLE, BUS_READ} pbt_bus_e;

  function automatic logic [PRE_W-1:0] pbt_pre_lim(input logic [2:0] ps);
    case (ps)
      3'h0: pbt_pre_lim = 8'h00;
      3'h1: pbt_pre_lim = 8'h01;
      3'h2: pbt_pre_lim = 8'h03;
      3'h3: pbt_pre_lim = 8'h07;
      3'h4: pbt_pre_lim = 8'h0F;
      3'h5: pbt_pre_lim = 8'h1F;
      3'h6: pbt_pre_lim = 8'h3F;
      default: pbt_pre_lim = 8'hFF;
    endcase
  endfunction : pbt_pre_lim

  function automatic logic [CNT_W-1:0] pbt_apply(input logic [CNT_W-1:0] old,
      input logic [CNT_W-1:0] wd, input logic [1:0] op);
    case (op)
      OP_WR: pbt_apply = wd;
      OP_CLR: pbt_apply = old & ~wd;
      OP_SET: pbt_apply = old | wd;
      default: pbt_apply = old ^ wd;
    endcase
  endfunction : pbt_apply

endpackage : pbt_pkg

// >>> pbt_timers_asserts.sv
// port assertions for the paired timer block
`timescale 1ns/1ns
module pbt_timers_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic adc_trigger,
  input wire logic [15:0] timebase_a,
  input wire logic [15:0] timebase_b
);
  // ====
  // recent register writes
  logic take;
  logic [2:0] wsh_q;
  assign take = hsel && hready && (htrans == 2'h2);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wsh_q <= 3'h0;
    end else begin
      wsh_q <= {wsh_q[1:0], take && hwrite};
    end
  end
  // ====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_resp_okay:
    assert property (hresp == 1'b0) else $error("bad response");
  a_read_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_nowait:
    assert property (take && hwrite |=> hreadyout) else $error("write wait");
  a_wait_cause:
    assert property ($fell(hreadyout) |-> $past(hwrite) == 1'b0) else $error("stray wait");
  a_rdata_hold:
    assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0) else $error("rdata moved");
  a_adc_wrap:
    assert property (adc_trigger |-> timebase_b == 16'h0) else $error("trigger without wrap");
  a_step_low:
    assert property (disable iff (!resetn || (wsh_q != 3'h0)) $changed(timebase_a) |->
      (timebase_a == $past(timebase_a) + 16'h1) || (timebase_a == 16'h0))
    else $error("low count jump");
  a_step_high:
    assert property (disable iff (!resetn || (wsh_q != 3'h0)) $changed(timebase_b) |->
      (timebase_b == $past(timebase_b) + 16'h1) || (timebase_b == 16'h0))
    else $error("high count jump");
endmodule : pbt_timers_chk

bind pbt_timers pbt_timers_chk u_chk (.clk(clk), .resetn(resetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .adc_trigger(adc_trigger),
  .timebase_a(timebase_a), .timebase_b(timebase_b));

// >>> tb_top.sv
// self-checking bench for the paired timers
`timescale 1ns/1ns
module tb_top;
  // ====
  // signals
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cpu_idle = 1'b0, hi_seen;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [3:0] pin = 4'h0;
  logic hreadyout, hresp, irq, adc_trigger;
  logic [15:0] tb_a, tb_b, t0, d;
  int fail_count = 0, n_checks = 0, adc_n = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (adc_trigger === 1'b1) adc_n++;
  pbt_timers dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer_ext_clock_pin(pin),
    .cpu_idle(cpu_idle), .irq(irq), .adc_trigger(adc_trigger), .timebase_a(tb_a),
    .timebase_b(tb_b));
  // ====
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] v);
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, v};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    xfer(a, 1'b1, v);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 16'h0);
    chk(rv, e);
  endtask : rdc
  task automatic dlt(input int n, input logic [15:0] e);
    @(posedge clk);
    t0 = tb_a;
    repeat (n) @(posedge clk);
    d = tb_a - t0;
    chk({16'h0, d}, {16'h0, e});
  endtask : dlt
  // ====
  // scenarios
  task automatic t_regs;
    rdc(12'h000, 32'h0);
    rdc(12'h020, 32'hFFFF);
    rdc(12'h200, 32'h0);
    wr(12'h040, 16'hFFFF);
    rdc(12'h040, 32'hA0F2);
    wr(12'h040, 16'h0000);
    wr(12'h000, 16'h7FFF);
    rdc(12'h000, 32'h20FA);
    wr(12'h000, 16'h0000);
    wr(12'h0A0, 16'h00F0);
    wr(12'h0A8, 16'h000F);
    rdc(12'h0A0, 32'h00FF);
    wr(12'h0A4, 16'h0003);
    wr(12'h0AC, 16'h00FF);
    rdc(12'h0A0, 32'h0003);
  endtask : t_regs
  task automatic t_count;
    wr(12'h000, 16'h8000);
    dlt(8, 16'h8);
    wr(12'h000, 16'h0000);
    wr(12'h000, 16'h8010);
    repeat (4) @(posedge clk);
    dlt(8, 16'h4);
    wr(12'h000, 16'h8080);
    dlt(8, 16'h0);
    pin[0] <= 1'b1;
    repeat (2) @(posedge clk);
    dlt(8, 16'h8);
    wr(12'h000, 16'h8002);
    pin[0] <= 1'b0;
    repeat (3) @(posedge clk);
    t0 = tb_a;
    repeat (4) begin
      pin[0] <= 1'b1;
      repeat (2) @(posedge clk);
      pin[0] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    d = tb_a - t0;
    chk({16'h0, d}, 32'h4);
    wr(12'h000, 16'hA000);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge clk);
    dlt(8, 16'h0);
    wr(12'h000, 16'h8000);
    dlt(8, 16'h8);
    cpu_idle <= 1'b0;
    wr(12'h000, 16'h0000);
  endtask : t_count
  task automatic t_wrap;
    wr(12'h110, 16'h0001);
    wr(12'h010, 16'h0000);
    wr(12'h020, 16'h0002);
    wr(12'h000, 16'h8000);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      t0 = tb_a;
      @(posedge clk);
      chk({16'h0, tb_a}, (t0 == 16'h2) ? 32'h0 : t0 + 32'h1);
    end
    chk(irq, 32'h1);
    wr(12'h000, 16'h0000);
    wr(12'h100, 16'h0001);
    rdc(12'h100, 32'h0);
    chk(irq, 32'h0);
    wr(12'h114, 16'h0001);
    wr(12'h000, 16'h8000);
    repeat (6) @(posedge clk);
    chk(irq, 32'h0);
    wr(12'h118, 16'h0001);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    wr(12'h000, 16'h0000);
    wr(12'h100, 16'h0001);
    wr(12'h110, 16'h0000);
  endtask : t_wrap
  task automatic t_pair;
    adc_n = 0;
    hi_seen = 1'b0;
    wr(12'h040, 16'h0002);
    wr(12'h010, 16'hFFFE);
    wr(12'h050, 16'h0000);
    wr(12'h020, 16'h0002);
    wr(12'h060, 16'h0001);
    wr(12'h000, 16'h8008);
    repeat (12) begin
      @(posedge clk);
      if (tb_b === 16'h1) hi_seen = 1'b1;
    end
    wr(12'h000, 16'h0008);
    @(posedge clk);
    chk(hi_seen, 32'h1);
    rdc(12'h100, 32'h2);
    chk(adc_n, 32'h1);
    wr(12'h040, 16'h2000);
    wr(12'h000, 16'h8008);
    cpu_idle <= 1'b1;
    dlt(8, 16'h0);
    wr(12'h044, 16'h2000);
    dlt(8, 16'h8);
    cpu_idle <= 1'b0;
    wr(12'h000, 16'h0008);
    @(posedge clk);
    wr(12'h100, 16'h0003);
    wr(12'h040, 16'h0000);
  endtask : t_pair
  // ====
  // run control
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_count;
    t_wrap;
    t_pair;
    summarize;
  end
endmodule : tb_top
